// >>> testbench/mac_rx_source.sv
// Purpose: Behavioural receive layer that feeds frames byte by byte
// Assumes: Driven on rising edges by non-blocking assignment
// Notes: Byte lane inverts when idle so stale data never looks valid
`timescale 1ns/1ps
module mac_rx_source (
    input logic clock,
    output logic frameStart = 1'b0,
    output logic byteValid = 1'b0,
    output logic [7:0] byteData = 8'h00,
    output logic frameEnd = 1'b0,
    output logic [2:0] dribbleBits = 3'h0,
    output logic crcBad = 1'b0,
    output logic lateCollision = 1'b0,
    output logic filterFail = 1'b0,
    output logic rxErPin = 1'b0
);
    // ==========================================
    // Frame task
    task automatic send(input int len, input logic [47:0] da, input logic [15:0] lt,
        input logic [2:0] drib, input logic crc, lc, ff, er);
        @(posedge clock);
        frameStart <= 1'b1;
        for (int i = 0; i < len; i++)
        begin
            @(posedge clock);
            frameStart <= 1'b0;
            byteValid <= 1'b1;
            byteData <= i < 6 ? da[47 - 8 * i -: 8] : i == 12 ? lt[15:8]
                : i == 13 ? lt[7:0] : i[7:0];
            rxErPin <= er && i == 20;
        end
        // Last byte goes before the end pulse so it is counted
        @(posedge clock);
        byteValid <= 1'b0;
        byteData <= ~byteData;
        frameEnd <= 1'b1;
        {dribbleBits, crcBad, lateCollision, filterFail} <= {drib, crc, lc, ff};
        @(posedge clock);
        frameEnd <= 1'b0;
    endtask
endmodule // mac_rx_source

// >>> testbench/rx_status_props.sv
// Purpose: Port assertions for the receive status word builder
// Assumes: One clock, synchronous active-low reset
// Notes: Status fields are judged in the read data cycle
`timescale 1ns/1ps
`include "rx_status_consts.vh"
module rx_status_props (
    input wire clock,
    input wire rst_n,
    input wire clkEn,
    input wire [7:0] regAddr,
    input wire regRd,
    input wire [31:0] regRdData,
    input wire frameEnd,
    input wire dataUnderrun,
    input wire receiverActive,
    input wire receiverHaltedIrq,
    input wire receiverFaultFlag,
    input wire statusAvail
);
    // ==========================================
    // Properties
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire stRd = clkEn && regRd && regAddr == `OFS_STATUS_PORT;
    wire [13:0] len = regRdData[29:16];
    rsv_bits_a: assert property (stRd |=> regRdData[31] == 1'b0 && regRdData[14] == 1'b0
        && regRdData[9:8] == 2'b00 && regRdData[0] == 1'b0) else $error("reserved bit set");
    err_sum_a: assert property (stRd |=> regRdData[15] == (regRdData[11] | regRdData[7]
        | regRdData[6] | regRdData[1])) else $error("error summary wrong");
    runt_len_a: assert property (stRd && statusAvail |=> regRdData[11] == (len < 14'd64))
        else $error("runt flag wrong");
    too_long_a: assert property (stRd && statusAvail |=> regRdData[7] == (len > 14'd1518))
        else $error("too long flag wrong");
    type_short_a: assert property (stRd |=> !(regRdData[5] && len < 14'd14))
        else $error("type set on short frame");
    dribble_coll_a: assert property (stRd |=> !(regRdData[2] && regRdData[6]))
        else $error("dribble beside late collision");
    halt_pulse_a: assert property (receiverHaltedIrq |-> !receiverActive
        ##1 !receiverHaltedIrq) else $error("halt pulse wrong");
    fault_set_a: assert property (clkEn && (dataUnderrun || stRd && !statusAvail)
        |=> receiverFaultFlag) else $error("fault flag not raised");
    queue_after_a: assert property ($rose(statusAvail) |-> $past(frameEnd))
        else $error("status queued without frame end");
    cover property (stRd && statusAvail);
    cover property (receiverHaltedIrq);
    cover property (receiverFaultFlag);
endmodule // rx_status_props

// >>> testbench/tb_top.sv
// Purpose: Self-checking bench for the receive status word builder
// Assumes: Clock enable held high, watchdog shortened to 1600 bytes
// Notes: Frame fields are random from a fixed xorshift seed; lengths cycle a fixed list of seven
`timescale 1ns/1ps
`include "rx_status_consts.vh"
module tb_top;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0000_0000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic speed10 = 1'b0;
    logic dataUnderrun = 1'b0;
    wire [31:0] regRdData;
    wire [7:0] byteData;
    wire [2:0] dribbleBits;
    wire frameStart, byteValid, frameEnd, crcBad, lateCollision, filterFail, rxErPin;
    wire receiverActive, receiverHaltedIrq, receiverFaultFlag, statusAvail;
    int miscompares = 0;
    int compares = 0;
    logic [31:0] seed = 32'h0000_3e52;
    logic [31:0] rd;
    logic [31:0] ex;
    always #2.5 clock = ~clock;
    // ==========================================
    // Instances
    mac_rx_source src_u (.clock(clock), .frameStart(frameStart), .byteValid(byteValid),
        .byteData(byteData), .frameEnd(frameEnd), .dribbleBits(dribbleBits), .crcBad(crcBad),
        .lateCollision(lateCollision), .filterFail(filterFail), .rxErPin(rxErPin));
    rx_status_word_builder #(.WDOG_LIMIT(1600)) dut_u (.clock(clock), .rst_n(rst_n),
        .clkEn(1'b1), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .frameStart(frameStart), .byteValid(byteValid),
        .byteData(byteData), .frameEnd(frameEnd), .dribbleBits(dribbleBits), .crcBad(crcBad),
        .lateCollision(lateCollision), .filterFail(filterFail), .speed10(speed10),
        .rxErPin(rxErPin), .dataUnderrun(dataUnderrun), .receiverActive(receiverActive),
        .receiverHaltedIrq(receiverHaltedIrq), .receiverFaultFlag(receiverFaultFlag),
        .statusAvail(statusAvail));
    // ==========================================
    // Helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [31:0] expWord(int len, logic [47:0] da, logic [15:0] lt,
        logic [2:0] drib, logic spd, crc, lc, ff, er);
        logic runt, tl, le, ty, dr;
        runt = len < 64;
        tl = len > 1518;
        ty = len >= 14 && lt > 16'd1500;
        le = len >= 14 && lt <= 16'd1500 && lt != len - 18 && !(len - 18 == 46 && lt < 16'd46);
        dr = !lc && (spd ? drib >= 3'd3 : drib == 3'd4);
        return {1'b0, ff, len[13:0], runt | tl | lc | crc | er, 1'b0, da == 48'hffff_ffff_ffff,
            le, runt, da[40], 2'b00, tl, lc, ty, len >= 1600, er, dr, crc | er, 1'b0};
    endfunction
    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic regWrite(logic [7:0] a, logic [31:0] d);
        @(posedge clock);
        {regAddr, regWrData, regWr} <= {a, d, 1'b1};
        @(posedge clock);
        regWr <= 1'b0;
    endtask
    task automatic regRead(logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        {regAddr, regRd} <= {a, 1'b1};
        @(posedge clock);
        regRd <= 1'b0;
        #1 d = regRdData;
    endtask
    task automatic complete_run();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ==========================================
    // Scenarios
    initial
    begin
        int len, hits;
        logic [47:0] da;
        logic [15:0] lt;
        logic crc, lc, ff, er;
        logic [2:0] drib;
        int lens [7] = '{10, 14, 63, 64, 200, 1519, 1700};
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        regWrite(`OFS_MAC_CONTROL, 32'h0001_0004);
        regRead(`OFS_MAC_CONTROL, rd);
        chk("control", rd, 32'h0001_0004);
        regRead(8'h40, rd);
        chk("unmapped", rd, 32'h0000_0000);
        for (int n = 0; n < 14; n++)
        begin
            len = lens[n % 7];
            rd = rnd();
            da = n % 3 == 0 ? 48'hffff_ffff_ffff : {rd[15:0], rnd()};
            lt = n % 2 ? rd[15:0] : 16'(len - 18);
            {crc, lc, ff, er} = rd[20:17];
            er = er && len >= 30;
            drib = rd[24:22];
            speed10 <= rd[21];
            src_u.send(len, da, lt, drib, crc, lc, ff, er);
            #1 chk("avail", {31'h0, statusAvail}, 32'h1);
            regRead(`OFS_STATUS_PORT, rd);
            // CRC bit carries no meaning for runts, late collisions or watchdog expiry
            hits = (len < 64 || lc || len >= 1600) ? 32'hffff_fffd : 32'hffff_ffff;
            ex = expWord(len, da, lt, drib, speed10, crc, lc, ff, er) & hits;
            rd = rd & hits;
            chk("status hi", rd >> 16, ex >> 16);
            chk("status class", rd & 32'h3c20, ex & 32'h3c20);
            chk("status err", rd & 32'hc3df, ex & 32'hc3df);
        end
        regRead(`OFS_STATUS_PORT, rd);
        chk("empty", rd, 32'h0000_0000);
        chk("fault", {31'h0, receiverFaultFlag}, 32'h1);
        regWrite(`OFS_RX_STATE, 32'h0000_0001);
        #1 chk("fault clear", {31'h0, receiverFaultFlag}, 32'h0);
        @(posedge clock);
        dataUnderrun <= 1'b1;
        @(posedge clock);
        dataUnderrun <= 1'b0;
        #1 chk("underrun", {31'h0, receiverFaultFlag}, 32'h1);
        regWrite(`OFS_MAC_CONTROL, 32'h0000_0004);
        src_u.send(30, 48'h0200_0000_0001, 16'h000c, 3'h0, 1'b0, 1'b0, 1'b0, 1'b0);
        #1 chk("runt drop", {31'h0, statusAvail}, 32'h0);
        regWrite(`OFS_MAC_CONTROL, 32'h0000_0000);
        hits = 0;
        repeat (6)
        begin
            #1 hits += receiverHaltedIrq;
            @(posedge clock);
        end
        chk("halt pulse", 32'(hits), 32'h1);
        chk("halted", {31'h0, receiverActive}, 32'h0);
        regWrite(`OFS_MAC_CONTROL, 32'h0000_0004);
        @(posedge clock);
        #1 chk("resumed", {31'h0, receiverActive}, 32'h1);
        src_u.send(64, 48'h0200_0000_0001, 16'h002e, 3'h0, 1'b0, 1'b0, 1'b0, 1'b0);
        #1 chk("kept", {31'h0, statusAvail}, 32'h1);
        regWrite(`OFS_MAC_CONTROL, 32'h0000_0000);
        regRead(`OFS_RX_STATE, rd);
        chk("state", rd, 32'h0000_0103);
        regWrite(`OFS_RX_STATE, 32'h0000_0003);
        regRead(`OFS_RX_STATE, rd);
        chk("flushed", rd, 32'h0000_0002);
        chk("flush empty", {31'h0, statusAvail}, 32'h0);
        complete_run();
    end
    initial
    begin
        repeat (40000) @(posedge clock);
        miscompares++;
        complete_run();
    end
endmodule // tb_top
bind rx_status_word_builder rx_status_props chk_u (.clock(clock), .rst_n(rst_n),
    .clkEn(clkEn), .regAddr(regAddr), .regRd(regRd), .regRdData(regRdData),
    .frameEnd(frameEnd), .dataUnderrun(dataUnderrun), .receiverActive(receiverActive),
    .receiverHaltedIrq(receiverHaltedIrq), .receiverFaultFlag(receiverFaultFlag),
    .statusAvail(statusAvail));

// >>> verilog/rx_status_consts.vh
// Purpose: Constants for the receive status word builder
// Assumes: Byte addresses on a 32-bit plain register port
// Notes: Offsets, field positions, reset values, byte counts and dribble bit counts
`ifndef RX_STATUS_CONSTS_VH
`define RX_STATUS_CONSTS_VH

// ==========================================================
// Register offsets
`define OFS_MAC_CONTROL 8'h00
`define OFS_STATUS_PORT 8'h04
`define OFS_RX_STATE 8'h08

// ==========================================================
// Control and state fields
`define CTRL_RX_ENABLE_BIT 2
`define CTRL_PASS_BAD_BIT 16
`define CTRL_RESET 32'h0000_0000
`define STATE_FAULT_BIT 0
`define STATE_HALTED_BIT 1
`define STATE_LEVEL_LSB 8

// ==========================================================
// Status word fields
`define ST_FILTER_FAIL 30
`define ST_LEN_MSB 29
`define ST_LEN_LSB 16
`define ST_ERR_SUMMARY 15
`define ST_BROADCAST 13
`define ST_LEN_MISMATCH 12
`define ST_RUNT 11
`define ST_MULTICAST 10
`define ST_TOO_LONG 7
`define ST_LATE_COLL 6
`define ST_FRAME_TYPE 5
`define ST_WATCHDOG 4
`define ST_MII_ERR 3
`define ST_DRIBBLE 2
`define ST_CRC_ERR 1

// ==========================================================
// Byte and dribble bit counts
`define MIN_FRAME_BYTES 14'd64
`define MAX_FRAME_BYTES 14'd1518
`define MAX_LEN_FIELD 16'd1500
`define MIN_TYPE_BYTES 14'd14
`define HDR_CRC_BYTES 14'd18
`define MIN_PAYLOAD 16'd46
`define WDOG_BYTES 2048
`define DRIB_MII 3'd4
`define DRIB_10M 3'd3

`endif

// >>> verilog/rx_status_word_builder.v
// Purpose: Builds the per-frame receive status word and queues it for the host
// Assumes: Frame byte stream from the MAC receive layer on the same clock
// Notes: Only the MII receive error pin is asynchronous and is synchronised
//
// Function
// RQ1 - Reserved status bits always read zero
// RQ2 - Bit 30 marks address filter failure
// RQ3 - Bits 29:16 hold frame byte count
// RQ4 - Bit 15 ORs bits 11,7,6,1
// RQ5 - Bit 13 marks broadcast destination
// RQ6 - Bit 12 flags length field mismatch
// RQ7 - Runt flag; runts queued only if pass-bad
// RQ8 - Bit 10 marks multicast destination
// RQ9 - Bit 7 over 1518 bytes, no truncation
// RQ10 - Bit 6 flags late collision
// RQ11 - Bit 5 type field above 1500
// RQ12 - Bit 4 flags receive watchdog expiry
// RQ13 - Bit 3 flags receive error seen
// RQ14 - Bit 2 dribble bits, not with late collision
// RQ15 - Bit 1 CRC error or receive error
// RQ16 - Host halts by clearing receive enable
// RQ17 - Single halted pulse once receiver stops
// RQ18 - Host may flush, then re-enables
// RQ19 - Fault flag on underruns or overrun
// RQ20 - Host recovers from reported faults
// RQ21 - Status word queued after frame data
// RQ22 - Per-frame flags cleared at frame start
`timescale 1ns/1ps
`include "rx_status_consts.vh"

module rx_status_word_builder #(
    parameter FIFO_DEPTH = 16,
    parameter FIFO_AW = 4,
    parameter WDOG_LIMIT = `WDOG_BYTES
) (
    input wire clock,
    input wire rst_n,
    input wire clkEn,
    input wire [7:0] regAddr,
    input wire [31:0] regWrData,
    input wire regWr,
    input wire regRd,
    output wire [31:0] regRdData,
    input wire frameStart,
    input wire byteValid,
    input wire [7:0] byteData,
    input wire frameEnd,
    input wire [2:0] dribbleBits,
    input wire crcBad,
    input wire lateCollision,
    input wire filterFail,
    input wire speed10,
    input wire rxErPin,
    input wire dataUnderrun,
    output wire receiverActive,
    output wire receiverHaltedIrq,
    output wire receiverFaultFlag,
    output wire statusAvail
);

    // ==========================================================
    // Receiver states
    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_FRAME = 2'b01;
    localparam [1:0] ST_HALT = 2'b10;
    localparam [31:0] WDOG_FULL = WDOG_LIMIT;
    localparam [13:0] WDOG_CNT = WDOG_FULL[13:0];

    // Dribble error only for a whole nibble on MII or three or more bits at 10 Mbps
    function dribbleError;
        input [2:0] bits;
        input slow;
        begin
            dribbleError = slow ? (bits >= `DRIB_10M) : (bits == `DRIB_MII);
        end
    endfunction

    // Register address decode shared by the read and write paths
    function regHit;
        input [7:0] addr;
        input [7:0] offset;
        begin
            regHit = (addr == offset);
        end
    endfunction

    // ==========================================================
    // Registers
    reg [31:0] ctrl_q;
    reg [1:0] state_q;
    reg [1:0] state_d;
    reg haltIrq_q;
    reg fault_q;
    reg [31:0] rdData_q;
    reg rxErMeta_q;
    reg rxErSync_q;
    reg [13:0] byteCnt_q;
    reg bcast_q;
    reg mcast_q;
    reg [15:0] typeField_q;
    reg wdog_q;
    reg miiErr_q;
    reg [31:0] mem [0:FIFO_DEPTH-1];
    reg [FIFO_AW:0] wrPtr_q;
    reg [FIFO_AW:0] rdPtr_q;

    wire rxEnable = ctrl_q[`CTRL_RX_ENABLE_BIT];
    wire passBad = ctrl_q[`CTRL_PASS_BAD_BIT];
    wire [FIFO_AW:0] level = wrPtr_q - rdPtr_q;
    wire fifoEmpty = (level == {(FIFO_AW+1){1'b0}});
    wire fifoFull = (level == FIFO_DEPTH[FIFO_AW:0]);
    wire inFrame = (state_q == ST_FRAME);
    wire takeByte = inFrame && byteValid;
    wire endNow = inFrame && frameEnd;
    wire rdStatus = regRd && regHit(regAddr, `OFS_STATUS_PORT);
    wire wrControl = regWr && regHit(regAddr, `OFS_MAC_CONTROL);
    wire wrState = regWr && regHit(regAddr, `OFS_RX_STATE);
    wire clearFault = wrState && regWrData[`STATE_FAULT_BIT];
    wire flushReq = wrState && regWrData[`STATE_HALTED_BIT] && (state_q == ST_HALT);

    // ==========================================================
    // Receive error pin synchroniser
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            rxErMeta_q <= 1'b0;
            rxErSync_q <= 1'b0;
        end
        else if (clkEn)
        begin
            rxErMeta_q <= rxErPin;
            rxErSync_q <= rxErMeta_q;
        end
    end

    // ==========================================================
    // Receiver control: a running frame always completes before the halt
    always @*
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE:
            begin
                if (!rxEnable)
                    state_d = ST_HALT; // RQ17
                else if (frameStart)
                    state_d = ST_FRAME;
            end
            ST_FRAME:
            begin
                if (frameEnd)
                    state_d = ST_IDLE;
            end
            ST_HALT:
            begin
                if (rxEnable)
                    state_d = ST_IDLE; // RQ18
            end
            default:
                state_d = ST_IDLE;
        endcase
    end

    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            state_q <= ST_HALT;
            haltIrq_q <= 1'b0;
        end
        else if (clkEn)
        begin
            state_q <= state_d;
            haltIrq_q <= (state_q == ST_IDLE) && (state_d == ST_HALT); // RQ17
        end
    end

    // ==========================================================
    // Per-frame collection
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            byteCnt_q <= 14'h0000;
            bcast_q <= 1'b0;
            mcast_q <= 1'b0;
            typeField_q <= 16'h0000;
            wdog_q <= 1'b0;
            miiErr_q <= 1'b0;
        end
        else if (clkEn)
        begin
            if ((state_q == ST_IDLE) && rxEnable && frameStart)
            begin
                byteCnt_q <= 14'h0000; // RQ22
                bcast_q <= 1'b1;
                mcast_q <= 1'b0;
                typeField_q <= 16'h0000;
                wdog_q <= 1'b0;
                miiErr_q <= 1'b0;
            end
            else if (inFrame)
            begin
                if (rxErSync_q)
                    miiErr_q <= 1'b1; // RQ13
                if (takeByte)
                begin
                    // Saturate; the frame itself is never cut short
                    if (byteCnt_q != 14'h3FFF)
                        byteCnt_q <= byteCnt_q + 14'h0001; // RQ9
                    if (byteCnt_q + 14'h0001 >= WDOG_CNT)
                        wdog_q <= 1'b1; // RQ12
                    if (byteCnt_q < 14'd6 && byteData != 8'hFF)
                        bcast_q <= 1'b0; // RQ5
                    if (byteCnt_q == 14'h0000)
                        mcast_q <= byteData[0]; // RQ8
                    if (byteCnt_q == 14'd12)
                        typeField_q[15:8] <= byteData;
                    if (byteCnt_q == 14'd13)
                        typeField_q[7:0] <= byteData;
                end
            end
        end
    end

    // ==========================================================
    // Status word assembly at frame end
    reg [31:0] statusWord;
    reg runt;
    reg tooLong;
    reg crcErr;
    reg lenMismatch;
    reg frameType;
    reg miiSeen;
    reg [15:0] payload;

    always @*
    begin
        miiSeen = miiErr_q || rxErSync_q;
        runt = (byteCnt_q < `MIN_FRAME_BYTES); // RQ7
        tooLong = (byteCnt_q > `MAX_FRAME_BYTES); // RQ9
        crcErr = crcBad || miiSeen; // RQ15
        payload = {2'b00, byteCnt_q} - {2'b00, `HDR_CRC_BYTES};
        frameType = (byteCnt_q >= `MIN_TYPE_BYTES) && (typeField_q > `MAX_LEN_FIELD); // RQ11
        // Padded short frames carry a length below the minimum payload
        lenMismatch = (byteCnt_q >= `MIN_TYPE_BYTES) && (typeField_q <= `MAX_LEN_FIELD)
            && (typeField_q != payload)
            && !((payload == `MIN_PAYLOAD) && (typeField_q < `MIN_PAYLOAD)); // RQ6
        statusWord = 32'h0000_0000; // RQ1
        statusWord[`ST_FILTER_FAIL] = filterFail; // RQ2
        statusWord[`ST_LEN_MSB:`ST_LEN_LSB] = byteCnt_q; // RQ3
        statusWord[`ST_BROADCAST] = bcast_q && (byteCnt_q >= 14'd6); // RQ5
        statusWord[`ST_LEN_MISMATCH] = lenMismatch; // RQ6
        statusWord[`ST_RUNT] = runt; // RQ7
        statusWord[`ST_MULTICAST] = mcast_q; // RQ8
        statusWord[`ST_TOO_LONG] = tooLong; // RQ9
        statusWord[`ST_LATE_COLL] = lateCollision; // RQ10
        statusWord[`ST_FRAME_TYPE] = frameType; // RQ11
        statusWord[`ST_WATCHDOG] = wdog_q; // RQ12
        statusWord[`ST_MII_ERR] = miiSeen; // RQ13
        statusWord[`ST_DRIBBLE] = dribbleError(dribbleBits, speed10) && !lateCollision; // RQ14
        statusWord[`ST_CRC_ERR] = crcErr; // RQ15
        statusWord[`ST_ERR_SUMMARY] = runt || tooLong || lateCollision || crcErr; // RQ4
    end

    // Data has already gone to the data FIFO when the end marker arrives
    wire keepFrame = !runt || passBad; // RQ7
    wire pushReq = endNow && keepFrame; // RQ21
    wire push = pushReq && !fifoFull;
    wire pop = rdStatus && !fifoEmpty;

    // ==========================================================
    // Status FIFO
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            wrPtr_q <= {(FIFO_AW+1){1'b0}};
            rdPtr_q <= {(FIFO_AW+1){1'b0}};
        end
        else if (clkEn)
        begin
            if (push)
            begin
                mem[wrPtr_q[FIFO_AW-1:0]] <= statusWord; // RQ21
                wrPtr_q <= wrPtr_q + 1'b1;
            end
            if (pop)
                rdPtr_q <= rdPtr_q + 1'b1;
            // Flush only while halted, so no frame is cut in two
            if (flushReq)
                rdPtr_q <= wrPtr_q + (push ? 1'b1 : 1'b0); // RQ18
        end
    end

    // ==========================================================
    // Register port and fault flag
    always @(posedge clock)
    begin
        if (!rst_n)
        begin
            ctrl_q <= `CTRL_RESET;
            fault_q <= 1'b0;
            rdData_q <= 32'h0000_0000;
        end
        else if (clkEn)
        begin
            if (wrControl)
                ctrl_q <= regWrData; // RQ16
            // Setting beats the write-one clear; reception keeps running
            if (dataUnderrun || (rdStatus && fifoEmpty) || (pushReq && fifoFull))
                fault_q <= 1'b1; // RQ19
            else if (clearFault)
                fault_q <= 1'b0; // RQ20
            rdData_q <= 32'h0000_0000;
            if (regRd)
            begin
                case (regAddr)
                    `OFS_MAC_CONTROL:
                        rdData_q <= ctrl_q;
                    `OFS_STATUS_PORT:
                        rdData_q <= fifoEmpty ? 32'h0000_0000 : mem[rdPtr_q[FIFO_AW-1:0]];
                    `OFS_RX_STATE:
                    begin
                        rdData_q[`STATE_FAULT_BIT] <= fault_q;
                        rdData_q[`STATE_HALTED_BIT] <= (state_q == ST_HALT);
                        rdData_q[`STATE_LEVEL_LSB+FIFO_AW:`STATE_LEVEL_LSB] <= level;
                    end
                    default:
                        rdData_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign regRdData = rdData_q;
    assign receiverActive = (state_q != ST_HALT);
    assign receiverHaltedIrq = haltIrq_q;
    assign receiverFaultFlag = fault_q;
    assign statusAvail = !fifoEmpty;

endmodule // rx_status_word_builder
